// File: inc/dcb_defines.svh
// Constants for the data channel block transfer controller.
`ifndef DCB_DEFINES_SVH
`define DCB_DEFINES_SVH

`define DCB_NCHAN       8
`define DCB_SINGLE_MASK 8'hF0
`define DCB_CLK_NS      5
`define DCB_CYC_NS      1000
`define DCB_CYC_CLKS    ((`DCB_CYC_NS + `DCB_CLK_NS - 1) / `DCB_CLK_NS)
`define DCB_WORD_RST    18'h0_0000

`endif

// File: inc/dcb_pkg.sv
// Types shared by the data channel controller.
package dcb_pkg;

  typedef logic [17:0] dcb_word_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WC     = 3'b001,
    ST_CA     = 3'b011,
    ST_SETTLE = 3'b010,
    ST_DATA   = 3'b110
  } dcb_state_e;

  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_REQ  = 2'b01,
    M_WR   = 2'b11,
    M_DONE = 2'b10
  } dcb_mstate_e;

  typedef struct packed {
    logic dir_out;
    logic incmem;
    logic addmem;
  } dcb_mode_s;

  typedef struct packed {
    logic      req;
    logic      wr;
    dcb_word_t addr;
    dcb_word_t wdata;
  } dcb_mem_s;

endpackage

// File: rtl/dcb_adder.sv
// Channel adder with increment input and inhibit.
module dcb_adder #(
  parameter int W = 18
) (
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  input  wire logic         inc,
  input  wire logic         inhibit,
  output logic      [W-1:0] sum,
  output logic              carry
);

  // Inhibit passes the first operand unchanged.
  assign {carry, sum} = inhibit ? {1'b0, a}
                                : ({1'b0, a} + {1'b0, b} + {{W{1'b0}}, inc});

endmodule // dcb_adder

// File: rtl/dcb_channel_ctrl.sv
// Data channel controller: grant, packet cycles, memory access and device bus.
`include "dcb_defines.svh"

module dcb_channel_ctrl #(
  parameter int                 NCHAN       = `DCB_NCHAN,
  parameter logic [NCHAN-1:0]   SINGLE_MASK = `DCB_SINGLE_MASK,
  parameter int                 CYC_CLKS    = `DCB_CYC_CLKS
) (
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic [NCHAN-1:0]    chan_req,
  output logic      [NCHAN-1:0]    chan_grant,
  input  wire dcb_pkg::dcb_mode_s  dev_mode,
  input  wire dcb_pkg::dcb_word_t  bus_addr_in,
  input  wire dcb_pkg::dcb_word_t  bus_data_in,
  output dcb_pkg::dcb_word_t       bus_data_out,
  output logic                     bus_data_oe,
  output logic                     dev_strobe,
  output logic      [NCHAN-1:0]    dev_ovf,
  output dcb_pkg::dcb_mem_s        mem_out,
  input  wire logic                mem_grant,
  input  wire dcb_pkg::dcb_word_t  mem_rdata,
  input  wire logic                cpu_mem_req,
  output logic                     cpu_mem_grant
);
  import dcb_pkg::*;

  localparam int CW = $clog2(CYC_CLKS);
  localparam int IW = $clog2(NCHAN);

  logic [CW-1:0]    div_q;
  logic             tick_q;
  logic [NCHAN-1:0] req_m_q;
  logic [NCHAN-1:0] req_s_q;
  dcb_word_t        addr_m_q;
  dcb_word_t        addr_s_q;
  dcb_word_t        data_m_q;
  dcb_word_t        data_s_q;
  dcb_mode_s        mode_m_q;
  dcb_mode_s        mode_s_q;
  dcb_state_e       state_q;
  dcb_state_e       nxt;
  dcb_mstate_e      mst_q;
  logic [IW-1:0]    ch_q;
  logic [IW-1:0]    pick_idx;
  logic             any_req;
  dcb_mode_s        mode_q;
  dcb_mode_s        m;
  logic             single_q;
  logic             sgl;
  logic             nmem;
  logic             mem_free;
  logic             adv;
  dcb_word_t        dsr_q;
  dcb_word_t        car_q;
  dcb_word_t        rd_q;
  dcb_word_t        launch_addr;
  dcb_word_t        add_a;
  dcb_word_t        add_b;
  logic             add_inc;
  logic             add_inh;
  dcb_word_t        add_sum;
  logic             add_co;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else if (div_q == CW'(CYC_CLKS - 1)) begin
      div_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // Request lines from the pins pass two flip-flops.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      req_m_q <= '0;
      req_s_q <= '0;
    end else begin
      req_m_q <= chan_req;
      req_s_q <= req_m_q;
    end
  end

  // Bus and mode lines from the pins pass two flip-flops.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      addr_m_q <= `DCB_WORD_RST;
      addr_s_q <= `DCB_WORD_RST;
      data_m_q <= `DCB_WORD_RST;
      data_s_q <= `DCB_WORD_RST;
      mode_m_q <= '0;
      mode_s_q <= '0;
    end else begin
      addr_m_q <= bus_addr_in;
      addr_s_q <= addr_m_q;
      data_m_q <= bus_data_in;
      data_s_q <= data_m_q;
      mode_m_q <= dev_mode;
      mode_s_q <= mode_m_q;
    end
  end

  always_comb begin
    pick_idx = '0;
    any_req  = |req_s_q;
    for (int i = NCHAN - 1; i >= 0; i--) begin
      if (req_s_q[i]) begin
        pick_idx = IW'(i);
      end
    end
  end

  assign mem_free = (mst_q == M_IDLE) || (mst_q == M_DONE);
  assign adv      = tick_q && mem_free && ((state_q != ST_IDLE) || (chan_grant != '0));

  // Next cycle of the sequence and whether it needs memory.
  always_comb begin
    m   = (state_q == ST_IDLE) ? mode_s_q : mode_q;
    sgl = (state_q == ST_IDLE) ? SINGLE_MASK[ch_q] : single_q;
    case (state_q)
      // Single-cycle goes straight to the data cycle.
      ST_IDLE:   nxt = sgl ? ST_DATA : ST_WC;
      ST_WC:     nxt = m.incmem ? ST_IDLE : ST_CA;
      ST_CA:     nxt = (m.dir_out || m.addmem) ? ST_SETTLE : ST_DATA;
      ST_SETTLE: nxt = ST_DATA;
      default:   nxt = ST_IDLE;
    endcase
    case (nxt)
      ST_WC:     nmem = 1'b1;
      ST_CA:     nmem = 1'b1;
      ST_SETTLE: nmem = m.dir_out && !m.addmem;
      ST_DATA:   nmem = sgl || !m.dir_out || m.addmem;
      default:   nmem = 1'b0;
    endcase
    if ((nxt == ST_SETTLE) || ((nxt == ST_DATA) && (state_q != ST_IDLE))) begin
      launch_addr = car_q;
    end else begin
      launch_addr = add_sum;
    end
  end

  // Adder operand selection.
  always_comb begin
    add_a   = rd_q;
    add_b   = '0;
    add_inc = 1'b0;
    add_inh = 1'b1;
    if (mst_q == M_WR) begin
      case (state_q)
        ST_WC: begin
          add_inc = 1'b1;
          add_inh = 1'b0;
        end
        ST_CA: begin
          add_inc = 1'b1;
          add_inh = 1'b0;
        end
        ST_DATA: begin
          if (mode_q.addmem && !single_q) begin
            add_b   = data_s_q;
            add_inh = 1'b0;
          end else if (!(single_q && mode_q.dir_out)) begin
            add_a = data_s_q;
          end
        end
        default: begin
          add_a = rd_q;
        end
      endcase
    end else if (state_q == ST_IDLE) begin
      add_a = addr_s_q;
    end else begin
      add_a   = dsr_q;
      add_inc = 1'b1;
      add_inh = 1'b0;
    end
  end

  dcb_adder #(
    .W       (18)
  ) u_adder (
    .a       (add_a),
    .b       (add_b),
    .inc     (add_inc),
    .inhibit (add_inh),
    .sum     (add_sum),
    .carry   (add_co)
  );

  // Grant register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      chan_grant <= '0;
      ch_q       <= '0;
    end else if ((state_q == ST_IDLE) && (chan_grant == '0) && any_req && tick_q) begin
      chan_grant <= NCHAN'(1) << pick_idx;
      ch_q       <= pick_idx;
    end else if (adv && (state_q == ST_IDLE)) begin
      chan_grant <= '0;
    end
  end

  // Sequence state and latched channel kind.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q  <= ST_IDLE;
      mode_q   <= '0;
      single_q <= 1'b0;
    end else if (adv) begin
      state_q <= nxt;
      if (state_q == ST_IDLE) begin
        mode_q   <= mode_s_q;
        single_q <= SINGLE_MASK[ch_q];
      end
    end
  end

  // Data storage register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dsr_q <= `DCB_WORD_RST;
    end else if (adv && (state_q == ST_IDLE)) begin
      dsr_q <= add_sum;
    end
  end

  // Current address register.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      car_q <= `DCB_WORD_RST;
    end else if (adv && (state_q == ST_IDLE)) begin
      car_q <= add_sum;
    end else if ((mst_q == M_WR) && (state_q == ST_CA)) begin
      car_q <= add_sum;
    end
  end

  // Memory read-pause-write sequencer.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mst_q   <= M_IDLE;
      mem_out <= '0;
      rd_q    <= `DCB_WORD_RST;
    end else begin
      mem_out.wr <= 1'b0;
      case (mst_q)
        M_REQ: begin
          if (mem_grant) begin
            rd_q        <= mem_rdata;
            mem_out.req <= 1'b0;
            mst_q       <= M_WR;
          end
        end
        M_WR: begin
          mem_out.wr    <= 1'b1;
          mem_out.wdata <= add_sum;
          mst_q         <= M_DONE;
        end
        default: begin
          if (adv && nmem) begin
            mem_out.req  <= 1'b1;
            mem_out.addr <= launch_addr;
            mst_q        <= M_REQ;
          end
        end
      endcase
    end
  end

  // Processor waits while the controller wants memory.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cpu_mem_grant <= 1'b0;
    end else begin
      cpu_mem_grant <= cpu_mem_req && (mst_q != M_REQ) && !(adv && nmem);
    end
  end

  // Device strobe at the end of the data cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dev_strobe <= 1'b0;
    end else begin
      dev_strobe <= adv && (state_q == ST_DATA);
    end
  end

  // Overflow pulse on the channel being served.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dev_ovf <= '0;
    end else if ((mst_q == M_WR) && (state_q == ST_WC) && add_co) begin
      dev_ovf <= NCHAN'(1) << ch_q;
    end else begin
      dev_ovf <= '0;
    end
  end

  // Data drive toward the device.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_data_out <= `DCB_WORD_RST;
      bus_data_oe  <= 1'b0;
    end else if ((mst_q == M_WR) && (state_q == ST_SETTLE)) begin
      bus_data_out <= rd_q;
      bus_data_oe  <= 1'b1;
    end else if ((mst_q == M_WR) && (state_q == ST_DATA)
                 && (mode_q.dir_out || mode_q.addmem)) begin
      bus_data_out <= add_sum;
      bus_data_oe  <= 1'b1;
    end else if ((state_q == ST_IDLE) && !dev_strobe) begin
      bus_data_oe <= 1'b0;
    end
  end

endmodule // dcb_channel_ctrl

// File: dv/dcb_ctrl_assertions.sv
// Concurrent checks on the data channel controller ports.
module dcb_ctrl_chk #(
  parameter int NCHAN = 8
) (
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic [NCHAN-1:0]  chan_req,
  input wire logic [NCHAN-1:0]  chan_grant,
  input wire logic              dev_strobe,
  input wire logic [NCHAN-1:0]  dev_ovf,
  input wire dcb_pkg::dcb_mem_s mem_out,
  input wire logic              mem_grant,
  input wire logic              cpu_mem_req,
  input wire logic              cpu_mem_grant
);
  timeunit 1ns;
  timeprecision 100ps;
  import dcb_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  grant_onehot_a: assert property ($onehot0(chan_grant))
    else $error("more than one grant");
  grant_cause_a: assert property ($rose(|chan_grant) |-> $past(|chan_req, 3))
    else $error("grant without request");
  grant_stands_a: assert property ($rose(|chan_grant) |=> $stable(chan_grant)[*8])
    else $error("grant dropped early");
  grant_mem_a: assert property ($rose(|chan_grant) |-> ##[1:40] mem_out.req)
    else $error("no memory request after grant");
  mem_req_holds_a: assert property (mem_out.req && !mem_grant |=>
    mem_out.req && $stable(mem_out.addr))
    else $error("memory request not held");
  write_after_grant_a: assert property (mem_out.wr |-> $past(mem_grant, 2))
    else $error("write without grant");
  cpu_lockout_a: assert property ($past(mem_out.req) |-> !cpu_mem_grant)
    else $error("processor granted over channel");
  cpu_cause_a: assert property (cpu_mem_grant |-> $past(cpu_mem_req))
    else $error("processor grant without request");
  ovf_pulse_a: assert property (|dev_ovf |=> !(|dev_ovf))
    else $error("overflow not a pulse");
  strobe_pulse_a: assert property (dev_strobe |=> !dev_strobe)
    else $error("strobe not a pulse");
endmodule // dcb_ctrl_chk

bind dcb_channel_ctrl dcb_ctrl_chk #(.NCHAN(NCHAN)) u_chk (.mclk, .sys_rst, .chan_req,
  .chan_grant, .dev_strobe, .dev_ovf, .mem_out, .mem_grant, .cpu_mem_req, .cpu_mem_grant);

// File: dv/dcb_dev_model.sv
// Behavioural device controller on the shared I/O bus.
module dcb_dev_model (
  input  wire logic               mclk,
  input  wire logic               sys_rst,
  input  wire logic               go,
  input  wire logic [7:0]         chm,
  input  wire dcb_pkg::dcb_word_t code,
  input  wire dcb_pkg::dcb_word_t data,
  input  wire dcb_pkg::dcb_mode_s mode,
  input  wire logic [7:0]         chan_grant,
  input  wire logic               dev_strobe,
  input  wire dcb_pkg::dcb_word_t bus_data_out,
  input  wire logic               bus_data_oe,
  input  wire logic [7:0]         dev_ovf,
  output logic [7:0]              chan_req,
  output dcb_pkg::dcb_word_t      bus_addr_in,
  output dcb_pkg::dcb_word_t      bus_data_in,
  output dcb_pkg::dcb_mode_s      dev_mode,
  output dcb_pkg::dcb_word_t      got,
  output logic [7:0]              ovf,
  output logic                    done,
  output int                      cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  import dcb_pkg::*;
  logic busy;
  logic gseen;
  initial {chan_req, bus_addr_in, bus_data_in, dev_mode, busy, gseen} = '0;
  always @(posedge mclk) begin
    done <= 1'b0;
    if (sys_rst) begin
      chan_req <= '0;
      busy     <= 1'b0;
    end else if (go) begin
      chan_req    <= chm;
      busy        <= 1'b1;
      gseen       <= 1'b0;
      cnt         <= 0;
      ovf         <= '0;
      bus_addr_in <= code;
      bus_data_in <= data;
      dev_mode    <= mode;
    end else begin
      if (|(chan_grant & chan_req)) begin
        chan_req <= chan_req & ~chan_grant;
        gseen    <= 1'b1;
      end
      if (gseen && busy) cnt <= cnt + 1;
      if (bus_data_oe) got <= bus_data_out;
      if (|dev_ovf) ovf <= dev_ovf;
      if (busy && dev_strobe) begin
        busy        <= 1'b0;
        done        <= 1'b1;
        bus_addr_in <= ~bus_addr_in;
        bus_data_in <= ~bus_data_in;
      end
    end
  end
endmodule // dcb_dev_model

// File: dv/tb_data_channel_block_transfer.sv
// Self-checking bench for the data channel controller.
module tb_data_channel_block_transfer;
  timeunit 1ns;
  timeprecision 100ps;
  import dcb_pkg::*;
  localparam int C = 16;
  logic       mclk = 0, sys_rst = 1, go = 0, cpu_mem_req = 0, mem_grant = 0;
  logic [7:0] chm = '0, fg = '0, chan_req, chan_grant, dev_ovf, ovf;
  dcb_word_t  code = '0, data = '0, mem_rdata = '0, bus_addr_in, bus_data_in;
  dcb_word_t  bus_data_out, got;
  dcb_mode_s  mode = '0, dev_mode;
  dcb_mem_s   mem_out;
  logic       bus_data_oe, dev_strobe, cpu_mem_grant, done;
  int         cnt, n_in, error_cnt = 0, cmp_count = 0;
  dcb_word_t  mem [0:1023];
  dcb_channel_ctrl #(.NCHAN(8), .SINGLE_MASK(8'hF0), .CYC_CLKS(C)) DUT (.mclk, .sys_rst,
    .chan_req, .chan_grant, .dev_mode, .bus_addr_in, .bus_data_in, .bus_data_out,
    .bus_data_oe, .dev_strobe, .dev_ovf, .mem_out, .mem_grant, .mem_rdata, .cpu_mem_req,
    .cpu_mem_grant);
  dcb_dev_model u_dev (.mclk, .sys_rst, .go, .chm, .code, .data, .mode, .chan_grant,
    .dev_strobe, .bus_data_out, .bus_data_oe, .dev_ovf, .chan_req, .bus_addr_in,
    .bus_data_in, .dev_mode, .got, .ovf, .done, .cnt);
  initial forever #2.5 mclk = ~mclk;
  // Prompt memory: one grant pulse per request, data valid with it.
  always @(posedge mclk) begin
    mem_grant <= mem_out.req && !mem_grant;
    mem_rdata <= mem_out.req ? mem[mem_out.addr[9:0]] : ~mem_rdata;
    if (mem_out.wr) mem[mem_out.addr[9:0]] <= mem_out.wdata;
    fg <= go ? 8'h00 : (fg != 8'h00 ? fg : chan_grant);
  end
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string nm, dcb_word_t e, dcb_word_t g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(logic [7:0] m, dcb_word_t a, dcb_word_t d, dcb_mode_s md, bit wend);
    @(posedge mclk);
    chm  <= m;
    code <= a;
    data <= d;
    mode <= md;
    go   <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (int i = 0; i < 8*C + 40; i++) begin
      @(negedge mclk);
      if (done || (wend && mem_out.wr)) begin
        @(negedge mclk);
        return;
      end
    end
    error_cnt++;
    $display("MISMATCH done exp 1 got 0");
    results();
  endtask
  task automatic t_multi();
    mem[30] = 18'h3_FFFE;
    mem[31] = 18'h0_0063;
    xfer(8'h01, 18'h0_001E, 18'h1_2345, 3'h0, 1'b0);
    chk("count", 18'h3_FFFF, mem[30]);
    chk("addr", 18'h0_0064, mem[31]);
    chk("data", 18'h1_2345, mem[100]);
    chk("ovf", 18'h0_0000, {10'h0, ovf});
    n_in = cnt;
    xfer(8'h01, 18'h0_001E, 18'h2_0F0F, 3'h0, 1'b0);
    chk("count0", 18'h0_0000, mem[30]);
    chk("ovf0", 18'h0_0001, {10'h0, ovf});
    chk("data2", 18'h2_0F0F, mem[101]);
    mem[32] = 18'h3_FFF0;
    mem[33] = 18'h0_00C7;
    mem[200] = 18'h2_5555;
    xfer(8'h02, 18'h0_0020, 18'h0_0000, 3'h4, 1'b0);
    chk("oaddr", 18'h0_00C8, mem[33]);
    chk("odata", 18'h2_5555, got);
    chk("ocyc", 18'(C), 18'(cnt - n_in));
    chk("cpu_on", 18'h0_0001, {17'h0, cpu_mem_grant});
    @(posedge mclk);
    cpu_mem_req <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk("cpu_off", 18'h0_0000, {17'h0, cpu_mem_grant});
    @(posedge mclk);
    cpu_mem_req <= 1'b1;
    $display("test multi done");
  endtask
  task automatic t_modes();
    xfer(8'h10, 18'h0_012C, 18'h0_ABCD, 3'h0, 1'b0);
    chk("sdata", 18'h0_ABCD, mem[300]);
    chk("scyc", 18'(n_in - 2*C), 18'(cnt));
    mem[50] = 18'h3_FFFF;
    mem[51] = 18'h0_0007;
    xfer(8'h04, 18'h0_0032, 18'h0_0000, 3'h2, 1'b1);
    chk("inc", 18'h0_0000, mem[50]);
    chk("incovf", 18'h0_0004, {10'h0, ovf});
    chk("incend", 18'h0_0007, mem[51]);
    mem[36] = 18'h3_FFF0;
    mem[37] = 18'h0_018F;
    mem[400] = 18'h0_000A;
    xfer(8'h08, 18'h0_0024, 18'h0_0005, 3'h1, 1'b0);
    chk("sum", 18'h0_000F, mem[400]);
    chk("sumdev", 18'h0_000F, got);
    chk("acyc", 18'(n_in + C), 18'(cnt));
    $display("test modes done");
  endtask
  task automatic t_prio();
    xfer(8'h28, 18'h0_0024, 18'h0_0007, 3'h0, 1'b0);
    chk("first", 18'h0_0008, {10'h0, fg});
    for (int i = 0; i < 4*C; i++) begin
      @(negedge mclk);
      if (chan_grant === 8'h20) break;
    end
    chk("second", 18'h0_0020, {10'h0, chan_grant});
    $display("test prio done");
  endtask
  initial begin
    @(posedge mclk);
    @(posedge mclk);
    sys_rst     <= 1'b0;
    cpu_mem_req <= 1'b1;
    t_multi();
    t_modes();
    t_prio();
    results();
  end
endmodule // tb_data_channel_block_transfer
